// ### printer_port.sv
// Purpose: printer port registers with compatible and EPP cycles
// Assumes: strobes, address and pins synchronous to clk
// Notes:   host bus and port data are split into in, out and enable
`timescale 1ns/1ps
`include "printer_port_cfg.svh"
// Contract
// RULE1: data latch resets zero, drives port lines
// RULE2: data read returns live port lines
// RULE3: status frozen from read strobe start
// RULE4: status bit0 timeout flag, write-one clears
// RULE5: status bits 1,2 read zero
// RULE6: status bit3 shows fault pin unchanged
// RULE7: bits 4-6 show online, paper, ack pins
// RULE8: status bit7 inverts printer occupied pin
// RULE9: control bits 0-5 reset; 6,7 zero
// RULE10: control bits 0,1,3 drive pins inverted
// RULE11: control bit2 drives printer reset directly
// RULE12: gated rising ack edge raises interrupt
// RULE13: direction bit only outside printer mode; EPP cycles use it in printer mode too
// RULE14: EPP address write cycle, trailing latch
// RULE15: EPP address read captures at strobe release
// RULE16: EPP windows answer only in EPP mode
// RULE17: status writable only in EPP mode
// RULE18: watchdog aborts cycle, sets status bit0
// RULE19: EPP handshake order with hold line
// RULE20: write with direction one runs read
// RULE21: timeout set beats simultaneous clear
module printer_port
(
  input  wire logic       clk,                       // 20 MHz system clock
  input  wire logic       rstn,                      // async reset, active low
  input  wire logic       ce,                        // clock enable
  input  wire logic       epp_mode_en,               // EPP mode selected
  input  wire logic       config_reg_one_b3,         // 1: printer mode, 0: extended
  input  wire logic [2:0] host_addr,                 // register offset
  input  wire logic       host_write_strobe_n,       // host write, active low
  input  wire logic       host_read_strobe_n,        // host read, active low
  input  wire logic [7:0] host_bus_in,               // host data in
  output logic [7:0]      host_bus_out,              // host data out
  output logic            host_bus_oe,               // host data drive enable
  output logic            host_ready,                // low stretches host cycle
  input  wire logic [7:0] port_data_in,              // port line levels
  output logic [7:0]      port_data_out,             // port line drive value
  output logic            port_data_oe,              // port line drive enable
  input  wire logic       fault_input_level,         // fault pin, low = error
  input  wire logic       on_line_input,             // printer on line
  input  wire logic       paper_out_input,           // paper end
  input  wire logic       char_taken_input_n,        // character acknowledge
  input  wire logic       printer_occupied_input_n,  // busy pin level
  input  wire logic       peripheral_hold_line_n,    // EPP wait, active low
  output logic            byte_valid_output_n,       // strobe pin
  output logic            line_feed_request_n,       // auto feed pin
  output logic            printer_reset_output_n,    // init pin
  output logic            choose_printer_output_n,   // select-in pin
  output logic            address_strobe_pin_n,      // EPP address strobe
  output logic            byte_strobe_pin_n,         // EPP data strobe
  output logic            direction_write_pin_n,     // EPP write, active low
  output logic            port_irq                   // interrupt request
);
  import printer_port_pkg::*;

  epp_req_if req_in ();
  epp_req_if req_out ();

  epp_state_e state_q, state_d;
  epp_req_s   cur_q, cur_d;
  logic [7:0] data_q, data_d, addr_q, addr_d, rcap_q, rcap_d;
  logic [7:0] wr_hold_q, wr_hold_d, snap_q, snap_d;
  logic [5:0] ctrl_q, ctrl_d;
  logic       tmo_q, tmo_d;
  logic       wr_prev_q, rd_prev_q, ack_prev_q;
  logic       wd_run, wd_expired;
  logic       wr_lead, wr_trail, rd_lead, rd_low;
  logic       epp_sel, reg_hit, write_eff, epp_active;
  logic [7:0] status_live;
  logic [7:0] hb_out_d, pd_out_d;
  logic       hb_oe_d, rdy_d, pd_oe_d, irq_d;
  logic       bv_d, lf_d, pr_d, cp_d, as_d, bs_d, dw_d;

  epp_req_buffer u_buf
  (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .fill  (req_in),
    .drain (req_out)
  );

  epp_watchdog u_wd
  (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .run     (wd_run),
    .expired (wd_expired)
  );

  // strobe edges; strobes arrive synchronous so no synchroniser is needed
  assign wr_lead  = wr_prev_q && !host_write_strobe_n;
  assign wr_trail = !wr_prev_q && host_write_strobe_n;
  assign rd_lead  = rd_prev_q && !host_read_strobe_n;
  assign rd_low   = !host_read_strobe_n;
  assign epp_sel  = epp_mode_en && (host_addr >= `OFS_EPP_ADDR); // RULE16
  assign reg_hit  = (host_addr < `OFS_EPP_ADDR) || epp_sel;      // RULE16

  // live status; bits 1 and 2 have no storage
  always_comb
  begin
    status_live            = 8'h00;                     // RULE5
    status_live[`ST_TMO]   = tmo_q;
    status_live[`ST_FAULT] = fault_input_level;         // RULE6
    status_live[`ST_ONLINE] = on_line_input;            // RULE7
    status_live[`ST_PAPER] = paper_out_input;           // RULE7
    status_live[`ST_ACK]   = char_taken_input_n;        // RULE7
    status_live[`ST_BUSY]  = ~printer_occupied_input_n; // RULE8
  end

  // EPP requests start on the leading edge
  always_comb
  begin
    req_in.valid        = (wr_lead || rd_lead) && epp_sel;   // RULE14
    req_in.req.is_addr  = (host_addr == `OFS_EPP_ADDR);
    req_in.req.is_read  = rd_lead;                           // RULE15
    req_in.req.data     = host_bus_in;
  end

  // EPP cycle engine
  assign wd_run     = (state_q == EPP_WAIT) || (state_q == EPP_STROBE);
  assign write_eff  = !cur_q.is_read && !ctrl_q[`CT_DIR];    // RULE20
  assign req_out.ready = (state_q == EPP_IDLE);
  always_comb
  begin
    state_d = state_q;
    cur_d   = cur_q;
    rcap_d  = rcap_q;
    unique case (state_q)
      EPP_IDLE:
      begin
        if (req_out.valid)
        begin
          cur_d   = req_out.req;
          state_d = EPP_WAIT;
        end
      end
      EPP_WAIT: // RULE19
      begin
        if (!peripheral_hold_line_n)
          state_d = EPP_STROBE;
      end
      EPP_STROBE: // RULE19
      begin
        if (peripheral_hold_line_n)
        begin
          rcap_d  = port_data_in; // RULE15
          state_d = EPP_RELEASE;
        end
      end
      EPP_RELEASE:
        state_d = EPP_FINISH;
      EPP_FINISH:
      begin
        if (host_write_strobe_n && host_read_strobe_n)
          state_d = EPP_IDLE;
      end
    endcase
    if (wd_expired && wd_run)
      state_d = EPP_FINISH; // RULE18
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= EPP_IDLE;
      cur_q   <= `REQ_RESET;
      rcap_q  <= `ADDR_RESET;
    end
    else if (ce)
    begin
      state_q <= state_d;
      cur_q   <= cur_d;
      rcap_q  <= rcap_d;
    end
  end

  // host-visible registers
  always_comb
  begin
    data_d    = data_q;
    addr_d    = addr_q;
    ctrl_d    = ctrl_q;
    tmo_d     = tmo_q;
    snap_d    = snap_q;
    wr_hold_d = host_write_strobe_n ? wr_hold_q : host_bus_in;
    if (wr_trail && host_addr == `OFS_DATA)
      data_d = wr_hold_q; // RULE1
    if (wr_trail && host_addr == `OFS_CONTROL)
      ctrl_d = wr_hold_q[5:0]; // RULE9
    if (wr_trail && host_addr == `OFS_EPP_ADDR && epp_mode_en)
      addr_d = wr_hold_q; // RULE14
    if (state_q == EPP_STROBE && state_d == EPP_RELEASE && cur_q.is_addr && cur_q.is_read)
      addr_d = rcap_d; // RULE15
    if (rd_lead && host_addr == `OFS_STATUS)
      snap_d = status_live; // RULE3
    // clear first so that a timeout in the same cycle wins
    if (wr_lead && host_addr == `OFS_STATUS && epp_mode_en && host_bus_in[`ST_TMO])
      tmo_d = 1'b0; // RULE4 RULE17
    if (wd_expired && wd_run)
      tmo_d = 1'b1; // RULE4 RULE18 RULE21
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_q    <= `DATA_RESET; // RULE1
      addr_q    <= `ADDR_RESET; // RULE14
      ctrl_q    <= `CTRL_RESET; // RULE9
      tmo_q     <= 1'b0; // RULE4
      snap_q    <= 8'h00;
      wr_hold_q <= 8'h00;
    end
    else if (ce)
    begin
      data_q    <= data_d;
      addr_q    <= addr_d;
      ctrl_q    <= ctrl_d;
      tmo_q     <= tmo_d;
      snap_q    <= snap_d;
      wr_hold_q <= wr_hold_d;
    end
  end

  // host read mux; a registered output adds one cycle to live views
  always_comb
  begin
    hb_out_d = 8'h00;
    unique case (host_addr)
      `OFS_DATA:     hb_out_d = port_data_in;                // RULE2
      `OFS_STATUS:   hb_out_d = rd_lead ? status_live : snap_q; // RULE3
      `OFS_CONTROL:  hb_out_d = {2'b00, ctrl_q};             // RULE9
      `OFS_EPP_ADDR: hb_out_d = addr_q;
      default:       hb_out_d = rcap_q;
    endcase
    hb_oe_d = rd_low && reg_hit;                             // RULE16
    rdy_d   = !(wd_run || req_out.valid || req_in.valid);    // RULE19
  end

  // port pins: EPP cycle overrides the plain register view
  assign epp_active = (state_d == EPP_STROBE) || (state_d == EPP_RELEASE);
  always_comb
  begin
    if (epp_active)
    begin
      pd_out_d = cur_d.data;
      pd_oe_d  = write_eff; // RULE20
      dw_d     = !pd_oe_d; // RULE19
    end
    else
    begin
      pd_out_d = data_q; // RULE1
      pd_oe_d  = config_reg_one_b3 || !ctrl_q[`CT_DIR]; // RULE13
      dw_d     = 1'b1;
    end
    as_d  = !(state_d == EPP_STROBE && cur_d.is_addr); // RULE19
    bs_d  = !(state_d == EPP_STROBE && !cur_d.is_addr); // RULE19
    bv_d  = ~ctrl_q[`CT_STROBE]; // RULE10
    lf_d  = ~ctrl_q[`CT_LINEFEED]; // RULE10
    cp_d  = ~ctrl_q[`CT_CHOOSE]; // RULE10
    pr_d  = ctrl_q[`CT_INIT]; // RULE11
    // held until ack falls again or the gate is closed
    irq_d = ctrl_q[`CT_IRQ_GATE] &&
            ((!ack_prev_q && char_taken_input_n) || (port_irq && char_taken_input_n)); // RULE12
  end

  // output and edge registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_bus_out            <= 8'h00;
      host_bus_oe             <= 1'b0;
      host_ready              <= 1'b1;
      port_data_out           <= `DATA_RESET;
      port_data_oe            <= 1'b1;
      byte_valid_output_n     <= 1'b1;
      line_feed_request_n     <= 1'b1;
      printer_reset_output_n  <= 1'b0;
      choose_printer_output_n <= 1'b1;
      address_strobe_pin_n    <= 1'b1;
      byte_strobe_pin_n       <= 1'b1;
      direction_write_pin_n   <= 1'b1;
      port_irq                <= 1'b0;
      wr_prev_q               <= 1'b1;
      rd_prev_q               <= 1'b1;
      ack_prev_q              <= 1'b1;
    end
    else if (ce)
    begin
      host_bus_out            <= hb_out_d;
      host_bus_oe             <= hb_oe_d;
      host_ready              <= rdy_d;
      port_data_out           <= pd_out_d;
      port_data_oe            <= pd_oe_d;
      byte_valid_output_n     <= bv_d;
      line_feed_request_n     <= lf_d;
      printer_reset_output_n  <= pr_d;
      choose_printer_output_n <= cp_d;
      address_strobe_pin_n    <= as_d;
      byte_strobe_pin_n       <= bs_d;
      direction_write_pin_n   <= dw_d;
      port_irq                <= irq_d;
      wr_prev_q               <= host_write_strobe_n;
      rd_prev_q               <= host_read_strobe_n;
      ack_prev_q              <= char_taken_input_n;
    end
  end
endmodule

// ### printer_port_cfg.svh
// Purpose: printer port offsets, bit positions, resets, counts
// Assumes: 20 MHz clock
// Notes:   definitions only
`ifndef PRINTER_PORT_CFG_SVH
`define PRINTER_PORT_CFG_SVH

// register offsets on the host address lines
`define OFS_DATA        3'h0
`define OFS_STATUS      3'h1
`define OFS_CONTROL     3'h2
`define OFS_EPP_ADDR    3'h3

// status bit positions
`define ST_TMO          0
`define ST_FAULT        3
`define ST_ONLINE       4
`define ST_PAPER        5
`define ST_ACK          6
`define ST_BUSY         7

// control bit positions
`define CT_STROBE       0
`define CT_LINEFEED     1
`define CT_INIT         2
`define CT_CHOOSE       3
`define CT_IRQ_GATE     4
`define CT_DIR          5

// reset values
`define DATA_RESET      8'h00
`define ADDR_RESET      8'h00
`define CTRL_RESET      6'h00
`define REQ_RESET       10'h000

// watchdog: a least time, rounded up to whole cycles
`define CLK_PERIOD_NS   50
`define EPP_TMO_US      10
`define EPP_TMO_CYC     ((`EPP_TMO_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// two-entry request buffer
`define BUF_DEPTH       2

`endif

// ### printer_port_pkg.sv
// Purpose: shared printer port types
// Assumes: nothing
// Notes:   state codes are Gray along idle-wait-strobe-release-finish
package printer_port_pkg;

  typedef enum logic [2:0]
  {
    EPP_IDLE    = 3'h0,
    EPP_WAIT    = 3'h1,
    EPP_STROBE  = 3'h3,
    EPP_RELEASE = 3'h2,
    EPP_FINISH  = 3'h6
  } epp_state_e;

  typedef struct packed
  {
    logic       is_addr;
    logic       is_read;
    logic [7:0] data;
  } epp_req_s;

endpackage

// ### epp_req_if.sv
// Purpose: valid/ready carrier for EPP cycle requests
// Assumes: one clock domain
// Notes:   src drives valid and data, snk drives ready
`timescale 1ns/1ps
interface epp_req_if;
  import printer_port_pkg::*;
  logic     valid;
  logic     ready;
  epp_req_s req;
  modport src (output valid, output req, input ready);
  modport snk (input valid, input req, output ready);
endinterface

// ### epp_req_buffer.sv
// Purpose: two-entry request buffer before the EPP engine
// Assumes: clock enable freezes all state
// Notes:   in.ready falls when both entries hold a request
`timescale 1ns/1ps
`include "printer_port_cfg.svh"
module epp_req_buffer
(
  input  wire logic clk,   // system clock
  input  wire logic rstn,  // async reset, active low
  input  wire logic ce,    // clock enable
  epp_req_if.snk    fill,  // filling side
  epp_req_if.src    drain  // draining side
);
  import printer_port_pkg::*;

  epp_req_s   mem_q [`BUF_DEPTH];
  epp_req_s   mem_d [`BUF_DEPTH];
  logic       wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  // handshakes on both sides
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;
  assign fill.ready  = (cnt_q != 2'(`BUF_DEPTH));
  assign drain.valid = (cnt_q != 2'h0);
  assign drain.req   = mem_q[rd_q];

  // pointers and occupancy
  always_comb
  begin
    wr_d  = push ? ~wr_q : wr_q;
    rd_d  = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end

  // one storage entry per index
  for (genvar i = 0; i < `BUF_DEPTH; i++)
  begin : g_ent
    always_comb
    begin
      mem_d[i] = (push && wr_q == 1'(i)) ? fill.req : mem_q[i];
    end
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        mem_q[i] <= `REQ_RESET;
      else if (ce)
        mem_q[i] <= mem_d[i];
    end
  end

  // pointer registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (ce)
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### epp_watchdog.sv
// Purpose: EPP wait watchdog
// Assumes: run is a level from the cycle engine
// Notes:   expired is a registered one-cycle pulse
`timescale 1ns/1ps
`include "printer_port_cfg.svh"
module epp_watchdog
(
  input  wire logic clk,     // system clock
  input  wire logic rstn,    // async reset, active low
  input  wire logic ce,      // clock enable
  input  wire logic run,     // cycle waiting on peripheral
  output logic      expired  // pulse: wait too long
);
  logic [7:0] cnt_q, cnt_d;
  logic       exp_d;

  // count only while running; restart whenever run drops
  always_comb
  begin
    cnt_d = run ? cnt_q + 8'h01 : 8'h00;
    exp_d = run && (cnt_q == 8'(`EPP_TMO_CYC)); // RULE18
    if (exp_d)
      cnt_d = 8'h00;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q   <= 8'h00;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q   <= cnt_d;
      expired <= exp_d;
    end
  end
endmodule

// ### printer_port_sva.sv
// Purpose: checks on printer port pins
// Assumes: one clock domain; ce held high by the bench
// Notes:   bound to every printer_port instance
`timescale 1ns/1ps
module printer_port_sva
(
  input wire logic       clk,                      // clock
  input wire logic       rstn,                     // reset, active low
  input wire logic       epp_mode_en,              // EPP mode
  input wire logic [2:0] host_addr,                // offset
  input wire logic       host_write_strobe_n,      // host write
  input wire logic       host_read_strobe_n,       // host read
  input wire logic [7:0] host_bus_in,              // write data
  input wire logic [7:0] host_bus_out,             // read data
  input wire logic       host_bus_oe,              // read drive
  input wire logic       host_ready,               // host stretch
  input wire logic [7:0] port_data_out,            // line value
  input wire logic       port_data_oe,             // line drive
  input wire logic       char_taken_input_n,       // ack pin
  input wire logic       peripheral_hold_line_n,   // wait pin
  input wire logic       byte_valid_output_n,      // strobe pin
  input wire logic       line_feed_request_n,      // feed pin
  input wire logic       printer_reset_output_n,   // init pin
  input wire logic       choose_printer_output_n,  // select pin
  input wire logic       address_strobe_pin_n,     // EPP addr strobe
  input wire logic       byte_strobe_pin_n,        // EPP data strobe
  input wire logic       direction_write_pin_n,    // EPP write
  input wire logic       port_irq                  // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [8:0] wait_q, wait_d;
  // stretch length; a hung peripheral must not hold the host
  always_comb wait_d = host_ready ? 9'h000 : wait_q + 9'h001;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      wait_q <= 9'h000;
    else
      wait_q <= wait_d;
  // a status read held long enough to be frozen
  sequence s_stat_rd;
    (host_addr == 3'h1 && !host_read_strobe_n) [*3];
  endsequence
  // a control read past its first cycle
  sequence s_ctrl_rd;
    (host_addr == 3'h2 && !host_read_strobe_n) [*2];
  endsequence
  // a write to the data offset, then its trailing edge
  property p_data_wr;
    logic [7:0] b;
    (!host_write_strobe_n && host_addr == 3'h0, b = host_bus_in) ##1 host_write_strobe_n
      |-> ##[1:3] port_data_out == b;
  endproperty
  AST_DATA_DRIVE: assert property (p_data_wr)
    else $error("data latch not on port lines");
  AST_STATUS_FROZEN: assert property (s_stat_rd |-> $stable(host_bus_out))
    else $error("status moved during read");
  AST_STATUS_ZERO: assert property ((host_bus_oe and s_stat_rd)
    |-> host_bus_out[2:1] == 2'b00)
    else $error("status bits 2:1 not zero");
  AST_CTRL_PINS: assert property (host_bus_oe ##0 s_ctrl_rd
    |-> host_bus_out[0] != byte_valid_output_n && host_bus_out[1] != line_feed_request_n
    && host_bus_out[2] == printer_reset_output_n && host_bus_out[3] != choose_printer_output_n
    && host_bus_out[7:6] == 2'b00)
    else $error("control pins disagree with readback");
  AST_IRQ_CAUSE: assert property (port_irq |-> $past(char_taken_input_n))
    else $error("irq without high ack pin");
  AST_EPP_REFUSED: assert property (!epp_mode_en && !$past(epp_mode_en)
    && host_addr >= 3'h3 && $past(host_addr) >= 3'h3 |-> !host_bus_oe)
    else $error("EPP window answered outside EPP mode");
  AST_STROBE_AFTER_WAIT: assert property ($fell(byte_strobe_pin_n & address_strobe_pin_n)
    |-> !$past(peripheral_hold_line_n))
    else $error("strobe before hold line asserted");
  AST_STROBE_STRETCH: assert property (!(byte_strobe_pin_n && address_strobe_pin_n)
    |-> !host_ready)
    else $error("host released during strobe");
  AST_WRITE_DRIVES: assert property (!direction_write_pin_n |-> port_data_oe)
    else $error("write direction without line drive");
  AST_WATCHDOG: assert property (wait_q < 9'd210)
    else $error("host stretched past watchdog");
endmodule
bind printer_port printer_port_sva sva (.*);

// ### epp_peripheral.sv
// Purpose: EPP peripheral model on the port lines
// Assumes: device pins registered on clk
// Notes:   delay sets hold release time; stuck never releases
`timescale 1ns/1ps
module epp_peripheral
(
  input  wire logic       clk,         // system clock
  input  wire logic       rstn,        // reset, active low
  input  wire logic [7:0] dev_out,     // device line value
  input  wire logic       dev_oe,      // device drives lines
  input  wire logic       addr_stb_n,  // address strobe
  input  wire logic       data_stb_n,  // data strobe
  input  wire logic       write_n,     // device writes when low
  input  wire logic [3:0] delay,       // cycles before release
  input  wire logic       stuck,       // never release hold
  input  wire logic       drive,       // drive lines in bidir mode
  input  wire logic [7:0] rd_byte,     // byte offered
  output logic            hold_n,      // wait line
  output logic [7:0]      lines,       // resolved line level
  output logic [7:0]      got,         // last byte taken
  output logic            got_addr     // it came with addr strobe
);
  logic       stb_n;
  logic [3:0] cnt;
  logic [7:0] pat;
  assign stb_n = addr_stb_n & data_stb_n;
  // undriven lines toggle every cycle so a stale byte never passes
  assign lines = dev_oe ? dev_out : ((!stb_n && write_n) || drive) ? rd_byte : pat;
  // hold idles asserted, releases after delay, reasserts once strobe drops
  always @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      hold_n <= 1'b0;
      cnt <= 4'h0;
      got <= 8'h00;
      got_addr <= 1'b0;
      pat <= 8'h5a;
    end
    else
    begin
      pat <= ~pat;
      if (stb_n)
      begin
        hold_n <= 1'b0;
        cnt <= 4'h0;
      end
      else if (!stuck && hold_n == 1'b0)
      begin
        if (cnt == delay)
        begin
          hold_n <= 1'b1;
          if (!write_n)
          begin
            got <= dev_out;
            got_addr <= !addr_stb_n;
          end
        end
        else
          cnt <= cnt + 4'h1;
      end
    end
endmodule

// ### printer_port_test.sv
// Purpose: self-checking bench for the printer port
// Assumes: inputs driven on falling edges; ce tied high
// Notes:   reads queue expectations; a monitor compares
`timescale 1ns/1ps
module printer_port_test;
  logic       clk, rstn, epp_mode_en, config_reg_one_b3, stuck, drive;
  logic       host_write_strobe_n, host_read_strobe_n, host_bus_oe, host_ready;
  logic [2:0] host_addr, a;
  logic [7:0] host_bus_in, host_bus_out, port_data_in, port_data_out, rd_byte, got, v;
  logic       port_data_oe, peripheral_hold_line_n, got_addr, port_irq;
  logic       byte_valid_output_n, line_feed_request_n, printer_reset_output_n;
  logic       choose_printer_output_n, address_strobe_pin_n, byte_strobe_pin_n;
  logic       direction_write_pin_n, fault_input_level, on_line_input, paper_out_input;
  logic       char_taken_input_n, printer_occupied_input_n;
  logic [4:0] stat_pins;
  logic [3:0] delay;
  logic [7:0] exp_q[$];
  int         seed, errors, check_count, i;
  event       rd_ev;
  assign {printer_occupied_input_n, char_taken_input_n, paper_out_input, on_line_input,
    fault_input_level} = stat_pins;
  printer_port dut (.*, .ce(1'b1));
  epp_peripheral far (.clk, .rstn, .dev_out(port_data_out), .dev_oe(port_data_oe),
    .addr_stb_n(address_strobe_pin_n), .data_stb_n(byte_strobe_pin_n),
    .write_n(direction_write_pin_n), .delay, .stuck, .drive, .rd_byte,
    .hold_n(peripheral_hold_line_n), .lines(port_data_in), .got, .got_addr);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // monitor: every read result takes the oldest note
  always @(rd_ev)
    chk("host_bus_out", exp_q.pop_front(), host_bus_out);
  // hold the strobe until the port lets the host go; a hang ends the run
  task automatic stretch();
    int n;
    repeat (2) @(negedge clk);
    for (n = 0; n < 400 && host_ready !== 1'b1; n++)
      @(negedge clk);
    if (host_ready !== 1'b1)
    begin
      errors++;
      test_done();
    end
    @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    host_addr = ad;
    host_bus_in = d;
    host_write_strobe_n = 1'b0;
    stretch();
    host_write_strobe_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // status pins move mid-read to prove the value is frozen
  task automatic rd(input logic [2:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    host_addr = ad;
    host_read_strobe_n = 1'b0;
    @(negedge clk);
    if (ad == 3'h1)
      stat_pins = 5'($random(seed));
    stretch();
    ->rd_ev;
    host_read_strobe_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [7:0] st(input logic t);
    return {~stat_pins[4], stat_pins[3:0], 2'b00, t};
  endfunction
  initial
  begin
    seed = 59511;
    {errors, check_count} = '0;
    {rstn, epp_mode_en, host_addr, host_bus_in, delay, stuck, drive, rd_byte} = '0;
    {config_reg_one_b3, host_write_strobe_n, host_read_strobe_n} = 3'b111;
    stat_pins = 5'h1f;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk("printer_reset_output_n", 8'h00, 8'(printer_reset_output_n));
    rd(3'h0, 8'h00);
    rd(3'h2, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      wr(3'h0, v);
      chk("port_data_out", v, port_data_out);
      rd(3'h0, v);
      v = 8'($random(seed));
      wr(3'h2, v);
      rd(3'h2, {2'b00, v[5:0]});
      chk("ctrl_pins", {4'h0, ~v[3], v[2], ~v[1], ~v[0]},
        {4'h0, choose_printer_output_n,
        printer_reset_output_n, line_feed_request_n, byte_valid_output_n});
      chk("port_data_oe", 8'h01, 8'(port_data_oe));
    end
    // bidirectional mode: peripheral drives, host reads the live lines
    config_reg_one_b3 = 1'b0;
    rd_byte = 8'($random(seed));
    drive = 1'b1;
    wr(3'h2, 8'h24);
    chk("port_data_oe", 8'h00, 8'(port_data_oe));
    rd(3'h0, rd_byte);
    wr(3'h2, 8'h04);
    {config_reg_one_b3, drive} = 2'b10;
    for (i = 0; i < 8; i++)
    begin
      stat_pins = 5'($random(seed));
      @(negedge clk);
      rd(3'h1, st(1'b0));
    end
    for (i = 3; i < 8; i++)
    begin
      host_addr = i[2:0];
      host_read_strobe_n = 1'b0;
      stretch();
      chk("host_bus_oe", 8'h00, 8'(host_bus_oe));
      host_read_strobe_n = 1'b1;
      repeat (2) @(negedge clk);
    end
    wr(3'h4, 8'h99);
    chk("epp_write", 8'h00, got);
    epp_mode_en = 1'b1;
    for (i = 0; i < 5; i++)
    begin
      v = 8'($random(seed));
      delay = 4'($random(seed));
      a = (i == 0) ? 3'h3 : 3'(i + 3);
      wr(a, v);
      chk("epp_write", v, got);
      chk("got_addr", 8'(i == 0), 8'(got_addr));
      rd_byte = 8'($random(seed));
      rd(a, rd_byte);
    end
    wr(3'h2, 8'h24);
    v = got;
    wr(3'h4, ~v);
    chk("epp_write", v, got);
    wr(3'h2, 8'h04);
    stuck = 1'b1;
    wr(3'h4, 8'h3c);
    stuck = 1'b0;
    rd(3'h1, st(1'b1));
    epp_mode_en = 1'b0;
    wr(3'h1, 8'h01);
    epp_mode_en = 1'b1;
    rd(3'h1, st(1'b1));
    wr(3'h1, 8'h00);
    rd(3'h1, st(1'b1));
    wr(3'h1, 8'h01);
    rd(3'h1, st(1'b0));
    // gated ack edge raises the interrupt, ungated does not
    for (i = 0; i < 2; i++)
    begin
      wr(3'h2, (i == 0) ? 8'h14 : 8'h04);
      stat_pins[3] = 1'b0;
      repeat (2) @(negedge clk);
      stat_pins[3] = 1'b1;
      repeat (3) @(negedge clk);
      chk("port_irq", 8'(i == 0), 8'(port_irq));
    end
    test_done();
  end
endmodule
